// ==== shared/kisel_defines.vh ====
// Purpose: constants for the key-input interrupt front end and vector-47 selector
// Assumes: AXI4-Lite byte addresses are four times the printed register index
// Notes: 50 MHz aclk
// Summary of operation
// - eight key pins large, four reduced
// - control bit 4 picks falling/rising edge
// - select bit 7 picks one/both edges
// - port bit 3 disables keys four-seven
// - port bit 7 disables keys zero-three
// - select bit 6 routes shared request source
// - interrupt 47 vector at offsets 188-191
`ifndef KISEL_DEFINES_VH
`define KISEL_DEFINES_VH
`define KISEL_IDX_KEY_CTRL 12'h04D
`define KISEL_IDX_SRC_SEL 12'h205
`define KISEL_IDX_PORT_CTRL 12'h366
`define KISEL_IDX_STATUS 12'h400
`define KISEL_IDX_MASK 12'h401
`define KISEL_IDX_RAW 12'h402
`define KISEL_BIT_POLARITY 4
`define KISEL_BIT_SRC_ROUTE 6
`define KISEL_BIT_BOTH_EDGE 7
`define KISEL_BIT_UPPER_DIS 3
`define KISEL_BIT_LOWER_DIS 7
`define KISEL_RST_KEY_CTRL 8'h00
`define KISEL_RST_SRC_SEL 8'h00
`define KISEL_RST_PORT_CTRL 8'h00
`define KISEL_VEC_NUM 8'h2F
`define KISEL_VEC_ADDR_LO 16'h00BC
`define KISEL_VEC_ADDR_HI 16'h00BF
`define KISEL_ST_KEY 0
`define KISEL_ST_SHARED 1
`define KISEL_RESP_OKAY 2'h0
`define KISEL_RESP_SLVERR 2'h2
`endif

// ==== hw/kisel_edge.v ====
// Purpose: one key pin edge detector
// Assumes: pin synchronous to aclk
// Notes: previous level reset high, keys idle high
module kisel_edge (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pin and mode
    input wire pin,
    input wire enable,
    input wire rising,
    input wire both,
    // result
    output reg hit
);
    reg last_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= 1'b1;
            hit <= 1'b0;
        end else begin
            last_q <= pin;
            if (!enable)
                hit <= 1'b0;
            else if (both)
                hit <= last_q ^ pin;
            else if (rising)
                hit <= ~last_q & pin;
            else
                hit <= last_q & ~pin;
        end
    end
endmodule

// ==== hw/kisel_route.v ====
// Purpose: shared vector-47 request selector
// Assumes: source requests are levels or pulses on aclk
// Notes: output registered, one cycle behind its source
module kisel_route (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // sources
    input wire route_rtc,
    input wire serial_req,
    input wire rtc_req,
    // result
    output reg shared_req
);
    always @(posedge aclk) begin
        if (!aresetn)
            shared_req <= 1'b0;
        else
            shared_req <= route_rtc ? rtc_req : serial_req;
    end
endmodule

// ==== hw/kisel_top.v ====
// Purpose: key-input interrupt front end with AXI4-Lite registers
// Assumes: key pins synchronous to aclk; one access of each kind at a time
// Notes: REDUCED=1 gives four keys and drops the polarity, both-edge and upper bits
`include "kisel_defines.vh"
module kisel_top #(
    parameter REDUCED = 0
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi write address
    input wire [13:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi read address
    input wire [13:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // key pins
    input wire [7:0] key_in,
    // shared request sources
    input wire serial_six_tx_req,
    input wire serial_six_not_acknowledge,
    input wire rtc_req,
    // interrupt requests to cpu
    output reg key_irq,
    output reg shared_irq,
    output wire [7:0] shared_vec_num,
    output wire [15:0] shared_vec_addr,
    output wire irq
);
    localparam NKEY = 8;

    reg [7:0] key_ctrl_q;
    reg [7:0] src_sel_q;
    reg [7:0] port_ctrl_q;
    reg [1:0] status_q;
    reg [1:0] mask_q;
    reg [13:0] awaddr_q;
    reg aw_full_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_full_q;

    wire [7:0] hit;
    wire shared_raw;
    wire lower_en;
    wire upper_en;
    wire rising;
    wire both;
    wire key_event;
    wire do_write;
    wire [11:0] widx;
    wire [11:0] ridx;
    wire [1:0] wclr;

    // the reduced part has no polarity or both-edge bit: falling single edge only
    assign rising = (REDUCED == 0) ? key_ctrl_q[`KISEL_BIT_POLARITY] : 1'b0;
    assign both = (REDUCED == 0) ? src_sel_q[`KISEL_BIT_BOTH_EDGE] : 1'b0;
    assign lower_en = ~port_ctrl_q[`KISEL_BIT_LOWER_DIS];
    assign upper_en = (REDUCED == 0) ? ~port_ctrl_q[`KISEL_BIT_UPPER_DIS] : 1'b0;

    genvar g;
    generate
        for (g = 0; g < NKEY; g = g + 1) begin : g_key
            kisel_edge u_edge (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin(key_in[g]),
                .enable((g < 4) ? lower_en : upper_en),
                .rising(rising),
                .both(both),
                .hit(hit[g])
            );
        end
    endgenerate

    kisel_route u_route (
        .aclk(aclk),
        .aresetn(aresetn),
        .route_rtc(src_sel_q[`KISEL_BIT_SRC_ROUTE]),
        .serial_req(serial_six_tx_req | serial_six_not_acknowledge),
        .rtc_req(rtc_req),
        .shared_req(shared_raw)
    );

    assign key_event = |hit;
    assign shared_vec_num = `KISEL_VEC_NUM;
    assign shared_vec_addr = `KISEL_VEC_ADDR_LO;

    always @(posedge aclk) begin
        if (!aresetn) begin
            key_irq <= 1'b0;
            shared_irq <= 1'b0;
        end else begin
            key_irq <= key_event;
            shared_irq <= shared_raw;
        end
    end

    // write channel: address and data accepted in either order
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign widx = awaddr_q[13:2];
    assign wclr = (do_write && widx == `KISEL_IDX_STATUS && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 14'h0000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `KISEL_RESP_OKAY;
            key_ctrl_q <= `KISEL_RST_KEY_CTRL;
            src_sel_q <= `KISEL_RST_SRC_SEL;
            port_ctrl_q <= `KISEL_RST_PORT_CTRL;
            mask_q <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `KISEL_RESP_OKAY;
                case (widx)
                    `KISEL_IDX_KEY_CTRL: begin
                        if (wstrb_q[0])
                            key_ctrl_q <= wdata_q[7:0];
                    end
                    `KISEL_IDX_SRC_SEL: begin
                        if (wstrb_q[0])
                            src_sel_q <= wdata_q[7:0];
                    end
                    `KISEL_IDX_PORT_CTRL: begin
                        if (wstrb_q[0])
                            port_ctrl_q <= wdata_q[7:0];
                    end
                    `KISEL_IDX_MASK: begin
                        if (wstrb_q[0])
                            mask_q <= wdata_q[1:0];
                    end
                    `KISEL_IDX_STATUS: begin
                    end
                    `KISEL_IDX_RAW: begin
                    end
                    default: s_axi_bresp <= `KISEL_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // sticky status: a new event beats a same-cycle clear
    always @(posedge aclk) begin
        if (!aresetn)
            status_q <= 2'b00;
        else
            status_q <= (status_q & ~wclr) | {shared_raw, key_event};
    end

    assign irq = |(status_q & mask_q);

    // read channel, one read at a time
    assign s_axi_arready = ~s_axi_rvalid;
    assign ridx = s_axi_araddr[13:2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `KISEL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `KISEL_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (ridx)
                `KISEL_IDX_KEY_CTRL: s_axi_rdata[7:0] <= key_ctrl_q;
                `KISEL_IDX_SRC_SEL: s_axi_rdata[7:0] <= src_sel_q;
                `KISEL_IDX_PORT_CTRL: s_axi_rdata[7:0] <= port_ctrl_q;
                `KISEL_IDX_STATUS: s_axi_rdata[1:0] <= status_q;
                `KISEL_IDX_MASK: s_axi_rdata[1:0] <= mask_q;
                `KISEL_IDX_RAW: s_axi_rdata[1:0] <= {shared_irq, key_irq};
                default: s_axi_rresp <= `KISEL_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== testbench/kisel_keys.sv ====
// Purpose: key switch bank on the key pins
// Assumes: switches idle high, pressed low
// Notes: no bounce, so edge counts stay exact
module kisel_keys (
    // clock
    input wire aclk,
    // pins
    output logic [7:0] key_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial key_in = 8'hFF;
    task automatic set(input logic [7:0] v);
        @(posedge aclk);
        key_in <= v;
    endtask
endmodule

// ==== testbench/kisel_top_asserts.sv ====
// Purpose: port checks for kisel_top
// Assumes: keys held idle high through reset
// Notes: route bit is hidden, so routing is judged from source levels
module kisel_top_asserts (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] key_in,
    input wire serial_six_tx_req,
    input wire serial_six_not_acknowledge,
    input wire rtc_req,
    input wire key_irq,
    input wire shared_irq,
    input wire [7:0] shared_vec_num,
    input wire [15:0] shared_vec_addr,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    vec_const_a: assert property (shared_vec_num == 8'h2F && shared_vec_addr == 16'h00BC)
        else $error("vector constant wrong");
    shared_off_a: assert property (!(serial_six_tx_req || serial_six_not_acknowledge || rtc_req)
        |-> ##2 !shared_irq) else $error("shared request without source");
    shared_on_a: assert property ((serial_six_tx_req || serial_six_not_acknowledge) && rtc_req
        |-> ##2 shared_irq) else $error("shared request missing");
    key_quiet_a: assert property ($stable(key_in) |-> ##2 !key_irq)
        else $error("key request without pin change");
    key_cause_a: assert property (key_irq |-> $past(key_in, 2) != $past(key_in, 3))
        else $error("key request not two cycles after change");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw ready during b");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready during r");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
endmodule
bind kisel_top kisel_top_asserts u_kisel_top_asserts (.*);

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for kisel_top
// Assumes: larger variant, status at 0x1000, mask at 0x1004
// Notes: fixed waits follow the stated key and shared latencies
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] key_in, shared_vec_num;
    logic [15:0] shared_vec_addr;
    logic serial_six_tx_req = 1'h0, serial_six_not_acknowledge = 1'h0, rtc_req = 1'h0;
    logic key_irq, shared_irq, irq;
    int fails = 0, samples_checked = 0;
    kisel_top u_kisel_top (.*);
    kisel_keys u_kisel_keys (.aclk(aclk), .key_in(key_in));
    initial forever #10 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [13:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic t_regs;
        logic [13:0] a [3] = '{14'h134, 14'h814, 14'hD98};
        foreach (a[i]) begin
            rd(a[i]);
            chk("reset value", d, 32'h0);
            wr(a[i], 8'hFF);
            rd(a[i]);
            chk("read back", d, 32'hFF);
            wr(a[i], 8'h00);
        end
        wr(14'h0100, 8'h01);
        chk("unmapped write", r, 2'h2);
        rd(14'h0100);
        chk("unmapped read data", d, 32'h0);
        chk("unmapped read resp", r, 2'h2);
    endtask
    // waits long enough for pin, edge, request and status stages
    task automatic kick(input logic [7:0] v, input logic e);
        wr(14'h1000, 8'h03);
        u_kisel_keys.set(v);
        repeat (5) @(posedge aclk);
        rd(14'h1000);
        chk("key status", d[0], e);
        chk("irq", irq, e);
    endtask
    task automatic t_keys;
        wr(14'h1004, 8'h03);
        kick(8'hFE, 1'h1);
        kick(8'hFF, 1'h0);
        wr(14'h134, 8'h10);
        kick(8'hFE, 1'h0);
        kick(8'hFF, 1'h1);
        wr(14'h814, 8'h80);
        kick(8'hFE, 1'h1);
        kick(8'hFF, 1'h1);
        wr(14'hD98, 8'h08);
        kick(8'hEF, 1'h0);
        kick(8'hFE, 1'h1);
        wr(14'hD98, 8'h80);
        kick(8'hFF, 1'h0);
        kick(8'h7F, 1'h1);
        wr(14'h1004, 8'h02);
        chk("masked irq", irq, 1'h0);
        wr(14'h1004, 8'h01);
        chk("unmasked irq", irq, 1'h1);
    endtask
    // fields: route, tx, nack, rtc, expected
    task automatic t_shared;
        logic [4:0] t [6] = '{5'h09, 5'h05, 5'h02, 5'h13, 5'h18, 5'h1B};
        foreach (t[i]) begin
            wr(14'h814, {1'h0, t[i][4], 6'h0});
            serial_six_tx_req <= t[i][3];
            serial_six_not_acknowledge <= t[i][2];
            rtc_req <= t[i][1];
            repeat (3) @(posedge aclk);
            chk("shared", shared_irq, t[i][0]);
        end
        rd(14'h1000);
        chk("shared status", d[1], 1'h1);
        rd(14'h1008);
        chk("raw requests", d, 32'h2);
        chk("vector number", shared_vec_num, 8'h2F);
        chk("vector address", shared_vec_addr, 16'h00BC);
    endtask
    task automatic stop_test;
        if (fails == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_keys;
        t_shared;
        stop_test;
    end
endmodule
